// *** common/rastk_defines.svh ***
`ifndef RASTK_DEFINES_SVH
`define RASTK_DEFINES_SVH

// register addresses in system bank 0
`define RASTK_PTR_ADDR 8'hDF
`define RASTK_ENTRY_BASE 8'hF0
`define RASTK_ENTRY_TOP 8'hFF

// pointer register fields
`define RASTK_IRQ_EN_BIT 7
`define RASTK_PTR_MSB 2

// reset values
`define RASTK_PTR_RESET 3'h7
`define RASTK_IRQ_EN_RESET 1'h0
`define RASTK_ENTRY_RESET 12'h000

`endif

// *** common/rastk_pkg.sv ***
package rastk_pkg;
  // kind of stack operation chosen each cycle
  typedef enum logic [1:0] {
    RASTK_OP_IDLE,
    RASTK_OP_PUSH,
    RASTK_OP_POP,
    RASTK_OP_REG
  } rastk_op_t;
endpackage : rastk_pkg

// *** src/rastk_mem.sv ***
`timescale 1ns/10ps
`include "rastk_defines.svh"

// small register-array memory for the return entries
module rastk_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // write port, mask picks the bits written
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [DW-1:0] wr_mask,
  // read port, registered data
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem_reg [DEPTH];
  logic [DW-1:0] mem_next [DEPTH];
  logic [DW-1:0] rd_data_next;

  // next value of each word
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en) begin
      mem_next[wr_addr] = (mem_reg[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
    rd_data_next = mem_reg[rd_addr];
  end

  // storage, entries clear to zero
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (srst) begin
        mem_reg[i] <= `RASTK_ENTRY_RESET;
      end else begin
        mem_reg[i] <= mem_next[i];
      end
    end
    if (srst) begin
      rd_data <= `RASTK_ENTRY_RESET;
    end else begin
      rd_data <= rd_data_next;
    end
  end

endmodule : rastk_mem

// *** src/rastk_top.sv ***
`timescale 1ns/10ps
`include "rastk_defines.svh"

module rastk_top #(
  parameter int DEPTH = 8,
  parameter int PW = 3,
  parameter int PCW = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // sequencer requests
  input wire logic call_push,
  input wire logic irq_push,
  input wire logic return_from_call,
  input wire logic return_from_irq,
  input wire logic [PCW-1:0] pc_in,
  // restored pc, valid one cycle after a pop
  output logic [PCW-1:0] pc_restore,
  output logic pc_restore_valid,
  // system register port, bank 0
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // interrupt enable to the core
  output logic global_irq_enable
);

  // empty-stack pointer and last entry index
  // the pointer counts down from all ones, a push at q takes entry last-q
  localparam logic [PW-1:0] PTR_EMPTY = PW'(`RASTK_PTR_RESET);
  localparam logic [PW-1:0] IDX_LAST = PW'(DEPTH - 1);

  // pointer and interrupt enable state
  // the enable shares the pointer register but moves only on its writes
  logic [PW-1:0] pointer_bits_reg;
  logic [PW-1:0] pointer_bits_next;
  logic irq_en_reg;
  logic irq_en_next;

  // restore strobe state
  logic pop_pending_reg;
  logic pop_pending_next;

  // read-back state, taken at the read edge
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic hi_sel_reg;
  logic hi_sel_next;
  logic rd_ptr_reg;
  logic rd_ptr_next;

  // operation and decoded request
  rastk_pkg::rastk_op_t op;
  logic push_req;
  logic pop_req;
  logic acc_req;
  logic ptr_hit;
  logic entry_hit;
  logic entry_hi;
  logic ptr_wr;
  logic entry_wr;
  logic [PW-1:0] entry_idx;
  logic [PW-1:0] pop_ptr;

  // memory port
  // the mask selects the bits a write changes
  logic mem_wr;
  logic [PW-1:0] mem_waddr;
  logic [PW-1:0] mem_raddr;
  logic [PCW-1:0] mem_wdata;
  logic [PCW-1:0] mem_wmask;
  logic [PCW-1:0] mem_rdata;

  // entry region 0xF0..0xFF: pairs of low/high bytes
  function automatic logic is_entry(input logic [7:0] a);
    return (a >= `RASTK_ENTRY_BASE) && (a <= `RASTK_ENTRY_TOP);
  endfunction : is_entry

  // entry number of an address in the entry region
  // even address low byte, odd address high byte
  function automatic logic [PW-1:0] entry_of(input logic [7:0] a);
    logic [7:0] off;
    off = a - `RASTK_ENTRY_BASE;
    return off[PW:1];
  endfunction : entry_of

  // entry a push writes at pointer q, counted down from the last index
  // a pop reads the slot of the pointer after its increment
  function automatic logic [PW-1:0] slot_of(input logic [PW-1:0] q);
    return PW'(IDX_LAST - q);
  endfunction : slot_of

  // pointer register image, enable on top
  // bits 6..3 read as zero, writes to them are dropped
  function automatic logic [7:0] ptr_image(input logic en, input logic [PW-1:0] q);
    logic [7:0] img;
    img = 8'h00;
    img[`RASTK_IRQ_EN_BIT] = en;
    img[PW-1:0] = q;
    return img;
  endfunction : ptr_image

  // one byte of an entry as seen on the register port, high byte with its high nibble zero
  function automatic logic [7:0] entry_byte(input logic [PCW-1:0] w, input logic hi);
    logic [7:0] b;
    b = w[7:0];
    if (hi) begin
      b = {{(16 - PCW){1'b0}}, w[PCW-1:8]};
    end
    return b;
  endfunction : entry_byte

  // address decode of the system register port
  assign ptr_hit = (reg_addr == `RASTK_PTR_ADDR);
  assign entry_hit = is_entry(reg_addr);
  assign entry_idx = entry_of(reg_addr);
  assign entry_hi = reg_addr[0]; // odd address is the high byte

  // request classes, core stack traffic wins over register access
  // a register write in a push or pop cycle is dropped, never delayed
  assign push_req = call_push || irq_push;
  assign pop_req = (return_from_call || return_from_irq) && !push_req;
  assign acc_req = (reg_wr || reg_rd) && !push_req && !pop_req;
  assign ptr_wr = acc_req && reg_wr && ptr_hit;
  assign entry_wr = acc_req && reg_wr && entry_hit;

  // pointer after a pop, whose top entry is read back
  assign pop_ptr = PW'(pointer_bits_reg + 1'b1);

  // one operation per cycle
  // push beats pop beats register access
  always_comb begin
    if (push_req) begin
      op = rastk_pkg::RASTK_OP_PUSH;
    end else if (pop_req) begin
      op = rastk_pkg::RASTK_OP_POP;
    end else if (acc_req) begin
      op = rastk_pkg::RASTK_OP_REG;
    end else begin
      op = rastk_pkg::RASTK_OP_IDLE;
    end
  end

  // memory port steering; byte writes are masked so the other byte keeps its bits
  // the memory reads the addressed entry in every idle or register cycle,
  // so a register read sees it after the next edge
  always_comb begin
    mem_wr = 1'b0;
    mem_waddr = entry_idx;
    mem_raddr = entry_idx;
    mem_wdata = '0;
    mem_wmask = '0;
    unique case (op)
      // push: whole word into the free slot
      rastk_pkg::RASTK_OP_PUSH: begin
        mem_wr = 1'b1;
        mem_waddr = slot_of(pointer_bits_reg);
        mem_wdata = pc_in;
        mem_wmask = '1;
      end
      // pop: read the current top
      rastk_pkg::RASTK_OP_POP: begin
        mem_raddr = slot_of(pop_ptr);
      end
      // register access: one byte of the addressed entry
      rastk_pkg::RASTK_OP_REG: begin
        mem_wr = entry_wr;
        if (entry_hi) begin
          mem_wdata[PCW-1:8] = reg_wdata[PCW-9:0];
          mem_wmask[PCW-1:8] = '1;
        end else begin
          mem_wdata[7:0] = reg_wdata;
          mem_wmask[7:0] = '1;
        end
      end
      // idle: no write
      rastk_pkg::RASTK_OP_IDLE: begin
        mem_wr = 1'b0;
      end
    endcase
  end

  // pointer and enable next values
  // the eighth push wraps the pointer back to all ones, a ninth reuses the oldest entry, no flag
  always_comb begin
    pointer_bits_next = pointer_bits_reg;
    irq_en_next = irq_en_reg;
    unique case (op)
      // push: move down
      rastk_pkg::RASTK_OP_PUSH: begin
        pointer_bits_next = PW'(pointer_bits_reg - 1'b1);
      end
      // pop: move up
      rastk_pkg::RASTK_OP_POP: begin
        pointer_bits_next = pop_ptr;
      end
      // register write: pointer bits and enable together
      rastk_pkg::RASTK_OP_REG: begin
        if (ptr_wr) begin
          pointer_bits_next = reg_wdata[`RASTK_PTR_MSB:0];
          irq_en_next = reg_wdata[`RASTK_IRQ_EN_BIT];
        end
      end
      // idle: hold
      rastk_pkg::RASTK_OP_IDLE: begin
        pointer_bits_next = pointer_bits_reg;
      end
    endcase
  end

  // register the pointer group, empty stack and interrupts off after reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pointer_bits_reg <= PTR_EMPTY;
      irq_en_reg <= `RASTK_IRQ_EN_RESET;
    end else begin
      pointer_bits_reg <= pointer_bits_next;
      irq_en_reg <= irq_en_next;
    end
  end

  // restore strobe follows every accepted pop by one cycle
  always_comb begin
    pop_pending_next = (op == rastk_pkg::RASTK_OP_POP);
  end

  // register the restore strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pop_pending_reg <= 1'b0;
    end else begin
      pop_pending_reg <= pop_pending_next;
    end
  end

  // read-back next values; the pointer image is caught at the read edge
  // byte select and pointer select follow the address every cycle,
  // the bus holds the address through the read cycle so they match the read
  always_comb begin
    rdata_next = rdata_reg;
    hi_sel_next = entry_hi;
    rd_ptr_next = ptr_hit;
    if (acc_req && reg_rd && ptr_hit) begin
      rdata_next = ptr_image(irq_en_reg, pointer_bits_reg);
    end
  end

  // register the read-back group
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
      hi_sel_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      hi_sel_reg <= hi_sel_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // eight entries of 12 bits
  // the memory clears with srst, so every entry reads zero after reset
  rastk_mem #(
    .DEPTH(DEPTH),
    .AW(PW),
    .DW(PCW)
  ) u_mem (
    .ref_clk(ref_clk),
    .srst(srst),
    .wr_en(mem_wr),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .wr_mask(mem_wmask),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // outputs
  // pc_restore is the memory read register, only meaningful
  // in the cycle in which pc_restore_valid is high
  assign pc_restore = mem_rdata;
  assign pc_restore_valid = pop_pending_reg;
  assign global_irq_enable = irq_en_reg;

  // read data: pointer from its register, entries from memory
  // the selects were taken with the read, so the byte matches the address
  always_comb begin
    if (rd_ptr_reg) begin
      reg_rdata = rdata_reg;
    end else begin
      reg_rdata = entry_byte(mem_rdata, hi_sel_reg);
    end
  end

endmodule : rastk_top

// *** verification/rastk_seq_model.sv ***
`timescale 1ns/10ps
// core sequencer stand-in, one request per cycle
module rastk_seq_model (
  // clock
  input wire logic ref_clk,
  // requests to the stack
  output logic call_push,
  output logic irq_push,
  output logic return_from_call,
  output logic return_from_irq,
  // pc offered with a push
  output logic [11:0] pc_in
);
  // idle at time zero
  initial {call_push, irq_push, return_from_call, return_from_irq, pc_in} = '0;
  // req is call, irq, return, irq return; pc bus toggles when unused
  task automatic step(input logic [3:0] req, input logic [11:0] pc);
    @(negedge ref_clk);
    {call_push, irq_push, return_from_call, return_from_irq} <= req;
    pc_in <= (req[3] | req[2]) ? pc : ~pc_in;
  endtask : step
endmodule : rastk_seq_model

// *** verification/rastk_top_properties.sv ***
`timescale 1ns/10ps
`include "rastk_defines.svh"
// port-level checks of stack and register port
module rastk_top_checker #(parameter int PCW = 12) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // stack port
  input wire logic call_push,
  input wire logic irq_push,
  input wire logic return_from_call,
  input wire logic return_from_irq,
  input wire logic [PCW-1:0] pc_in,
  input wire logic [PCW-1:0] pc_restore,
  input wire logic pc_restore_valid,
  input wire logic global_irq_enable,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // push beats pop beats register access
  wire logic push = call_push | irq_push;
  wire logic pop = (return_from_call | return_from_irq) & !push;
  wire logic acc = !push & !(return_from_call | return_from_irq);
  wire logic ptr_hit = reg_addr == `RASTK_PTR_ADDR;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_valid; pop |=> pc_restore_valid; endproperty
  a_valid: assert property (p_valid) else $error("no restore after pop");
  property p_quiet; !pop |=> !pc_restore_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("restore without pop");
  property p_lifo; push ##1 pop |=> pc_restore == $past(pc_in, 2); endproperty
  a_lifo: assert property (p_lifo) else $error("pop not last pushed");
  property p_irq_en_wr; acc && reg_wr && ptr_hit |=> global_irq_enable == $past(reg_wdata[7]); endproperty
  a_irq_en_wr: assert property (p_irq_en_wr) else $error("enable not written");
  property p_irq_en_hold; !(reg_wr && ptr_hit) |=> $stable(global_irq_enable); endproperty
  a_irq_en_hold: assert property (p_irq_en_hold) else $error("enable moved");
  property p_unmap; acc && reg_wr && !ptr_hit && reg_addr < 8'hF0 |=> $stable(global_irq_enable)[*2]; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped write acted");
  property p_ptr_rd; acc && reg_rd && ptr_hit |=> reg_rdata[6:3] == 4'h0 && reg_rdata[7] == $past(global_irq_enable); endproperty
  a_ptr_rd: assert property (p_ptr_rd) else $error("pointer read bad");
  property p_high; acc && reg_rd && reg_addr >= 8'hF0 && reg_addr[0] |=> reg_rdata[7:4] == 4'h0; endproperty
  a_high: assert property (p_high) else $error("high nibble not zero");
endmodule : rastk_top_checker
bind rastk_top rastk_top_checker #(.PCW(PCW)) u_chk (.*);

// *** verification/return_address_stack_test.sv ***
`timescale 1ns/10ps
`include "rastk_defines.svh"
module return_address_stack_test;
  // bench-driven inputs and design outputs
  logic ref_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  wire logic call_push, irq_push, return_from_call, return_from_irq;
  wire logic [11:0] pc_in;
  logic [11:0] pc_restore;
  logic pc_restore_valid, global_irq_enable;
  int failures = 0, samples_checked = 0;
  // 125 MHz clock
  initial forever #4 ref_clk = ~ref_clk;
  rastk_seq_model seq (.*);
  rastk_top dut (.*);
  // test pc pattern
  function automatic logic [11:0] pcv(input int i);
    return 12'(i * 12'h137 + 12'h0A5);
  endfunction : pcv
  // compare and count
  task automatic chk(input string n, input logic [11:0] e, s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // register read, data the cycle after
  task automatic rd(input logic [7:0] a, e);
    @(negedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(negedge ref_clk);
    reg_rd <= 1'h0;
    chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
  endtask : rd
  // register write
  task automatic wr(input logic [7:0] a, d);
    @(negedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  // pop, then check the restored pc
  task automatic pop(input logic [11:0] e, input logic [3:0] r);
    seq.step(r, 12'h000);
    seq.step(4'h0, 12'h000);
    chk("pc_restore_valid", 12'h001, {11'h000, pc_restore_valid});
    chk("pc_restore", e, pc_restore);
  endtask : pop
  // verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // hang guard
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  // main sequence
  initial begin
    logic [11:0] v;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    srst <= 1'h0;
    rd(`RASTK_PTR_ADDR, 8'h07);
    rd(`RASTK_ENTRY_BASE, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seq.step(i[0] ? 4'h4 : 4'h8, pcv(i));
      seq.step(4'h0, 12'h000);
      rd(`RASTK_PTR_ADDR, {5'h00, 3'(6 - i)});
    end
    for (int i = 0; i < 8; i++) begin
      v = pcv(i);
      rd(8'(`RASTK_ENTRY_BASE + 2 * i), v[7:0]);
      rd(8'(`RASTK_ENTRY_BASE + 2 * i + 1), {4'h0, v[11:8]});
    end
    for (int i = 7; i >= 0; i--) pop(pcv(i), i[0] ? 4'h1 : 4'h2);
    rd(`RASTK_PTR_ADDR, 8'h07);
    // nine pushes back to back, straight into a pop
    for (int i = 0; i < 9; i++) seq.step(4'h4, pcv(i + 8));
    pop(pcv(16), 4'h1);
    v = pcv(16);
    rd(`RASTK_ENTRY_BASE, v[7:0]);
    rd(`RASTK_PTR_ADDR, 8'h07);
    // byte writes to entry 3 keep the other byte
    v = pcv(11);
    wr(8'(`RASTK_ENTRY_BASE + 7), 8'hFA);
    rd(8'(`RASTK_ENTRY_BASE + 7), 8'h0A);
    rd(8'(`RASTK_ENTRY_BASE + 6), v[7:0]);
    wr(8'(`RASTK_ENTRY_BASE + 6), 8'h3C);
    rd(8'(`RASTK_ENTRY_BASE + 6), 8'h3C);
    rd(8'(`RASTK_ENTRY_BASE + 7), 8'h0A);
    // unmapped write, then enable and pointer writes
    wr(8'h50, 8'h80);
    rd(`RASTK_PTR_ADDR, 8'h07);
    wr(`RASTK_PTR_ADDR, 8'h85);
    chk("global_irq_enable", 12'h001, {11'h000, global_irq_enable});
    rd(`RASTK_PTR_ADDR, 8'h85);
    wr(`RASTK_PTR_ADDR, 8'h07);
    rd(`RASTK_PTR_ADDR, 8'h07);
    end_sim();
  end
endmodule : return_address_stack_test
